// ==== hw/gpc_cfg.svh ====
// Register map, field positions and reset values of the pin block
// Functional notes
// - Pin2 pull field: none, down, up; resets down
// - Pin2 input buffer enable; resets off
// - Pin2 driver enable, else high impedance; resets 0
// - Input register returns sampled levels of pins whose input buffer is enabled; other bits read 0
// - Output register bits drive the pins whose gpout_sel bit selects the output register; other pins follow alt_out
// - Output bit 2 drives pin2; resets 0
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define GPC_ADDR_W 8
`define GPC_DATA_W 8
`define GPC_OFS_PIN2_CFG 8'h04
`define GPC_OFS_PIN_IN 8'h05
`define GPC_OFS_PIN_OUT 8'h06

// ****************************************
// Field positions of the pin2 configuration register
// ****************************************
`define GPC_CFG_MODE_HI 7
`define GPC_CFG_MODE_LO 4
`define GPC_CFG_PULL_HI 3
`define GPC_CFG_PULL_LO 2
`define GPC_CFG_INEN_BIT 1
`define GPC_CFG_DRV_BIT 0

// ****************************************
// Reset values and pull encodings
// ****************************************
`define GPC_RST_MODE 4'h0
`define GPC_RST_PULL 2'h1
`define GPC_RST_INEN 1'h0
`define GPC_RST_DRV 1'h0
`define GPC_RST_OUT 3'h0
`define GPC_PULL_NONE 2'h0
`define GPC_PULL_DOWN 2'h1
`define GPC_PULL_UP 2'h2
`define GPC_NUM_PINS 3

`endif

// ==== hw/gpc_pkg.sv ====
// Types shared by the pin block
`include "gpc_cfg.svh"
package gpc_pkg;

	// Stored content of the pin2 configuration register
	typedef struct packed {
		logic [3:0] mode;
		logic [1:0] pull;
		logic in_en;
		logic drv_on;
	} gpc_cfg_s;

	// Pad resistor controls seen by the pin2 pad cell
	typedef struct packed {
		logic pull_up;
		logic pull_down;
	} gpc_pull_s;

	// Register access request from the management bus engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`GPC_ADDR_W-1:0] addr;
		logic [`GPC_DATA_W-1:0] wdata;
	} gpc_req_s;

endpackage

// ==== hw/gpc_top.sv ====
// Pin configuration, input and output registers with pin drive logic
`timescale 1ns/10ps
`include "gpc_cfg.svh"
module gpc_top #(
	parameter int DATA_W = `GPC_DATA_W,
	parameter int NUM_PINS = `GPC_NUM_PINS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register access from the management bus engine
	input wire gpc_pkg::gpc_req_s req,
	output logic [DATA_W-1:0] rdata,
	output logic rvalid,
	// Settings of pins 0 and 1 held by other configuration registers
	input wire logic [NUM_PINS-2:0] other_in_en,
	input wire logic [NUM_PINS-2:0] other_drv_on,
	// Per-pin output source: 1 selects the output register
	input wire logic [NUM_PINS-1:0] gpout_sel,
	input wire logic [NUM_PINS-1:0] alt_out,
	// Pads
	input wire logic [NUM_PINS-1:0] pin_i,
	output logic [NUM_PINS-1:0] pin_o,
	output logic [NUM_PINS-1:0] pin_oe,
	output gpc_pkg::gpc_pull_s pin2_pull,
	output logic [3:0] pin2_mode
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (DATA_W != `GPC_DATA_W || NUM_PINS != `GPC_NUM_PINS) begin : g_chk
		$error("gpc_top: register layout fixes 8 data bits and 3 pins");
	end

	// Stored fields must fill exactly one register word
	if ($bits(gpc_pkg::gpc_cfg_s) != DATA_W) begin : g_chk_cfg
		$error("gpc_top: pin2 configuration fields do not fill a word");
	end

	// ****************************************
	// Registers
	// ****************************************
	gpc_pkg::gpc_cfg_s cfg_q;
	logic [NUM_PINS-1:0] out_q;
	logic [NUM_PINS-1:0] in_q;
	logic [NUM_PINS-1:0] in_en;
	logic [DATA_W-1:0] rdata_q;
	logic rvalid_q;

	function automatic logic hit(input gpc_pkg::gpc_req_s r,
		input logic [`GPC_ADDR_W-1:0] ofs);
		hit = (r.addr == ofs);
	endfunction

	// Pin2 configuration register
	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg_q.pull <= `GPC_RST_PULL;
			cfg_q.in_en <= `GPC_RST_INEN;
			cfg_q.drv_on <= `GPC_RST_DRV;
			cfg_q.mode <= `GPC_RST_MODE;
		end else if (req.wr && hit(req, `GPC_OFS_PIN2_CFG)) begin
			cfg_q.mode <= req.wdata[`GPC_CFG_MODE_HI:`GPC_CFG_MODE_LO];
			cfg_q.pull <= req.wdata[`GPC_CFG_PULL_HI:`GPC_CFG_PULL_LO];
			cfg_q.in_en <= req.wdata[`GPC_CFG_INEN_BIT];
			cfg_q.drv_on <= req.wdata[`GPC_CFG_DRV_BIT];
		end
	end

	// Output level register
	always_ff @(posedge mclk) begin
		if (reset) begin
			out_q <= `GPC_RST_OUT;
		end else if (req.wr && hit(req, `GPC_OFS_PIN_OUT)) begin
			out_q <= req.wdata[NUM_PINS-1:0];
		end
	end

	// ****************************************
	// Pin drive and sampling
	// ****************************************
	assign in_en = {cfg_q.in_en, other_in_en};

	// Pads are driven from flops so glitches on the muxes never reach a pin
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		always_ff @(posedge mclk) begin
			if (reset) begin
				pin_o[i] <= 1'h0;
			end else begin
				pin_o[i] <= gpout_sel[i] ? out_q[i] : alt_out[i];
			end
		end

		always_ff @(posedge mclk) begin
			if (reset) begin
				in_q[i] <= 1'h0;
			end else begin
				in_q[i] <= pin_i[i] & in_en[i];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_oe <= '0;
		end else begin
			// pin2 driver follows its enable bit
			pin_oe <= {cfg_q.drv_on, other_drv_on};
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pin2_pull <= '0;
		end else begin
			pin2_pull.pull_up <= (cfg_q.pull == `GPC_PULL_UP);
			pin2_pull.pull_down <= (cfg_q.pull == `GPC_PULL_DOWN);
		end
	end

	assign pin2_mode = cfg_q.mode;

	// ****************************************
	// Read path
	// ****************************************
	// Unmapped offsets return zero, so software can probe the map safely
	function automatic logic [DATA_W-1:0] read_mux(
		input logic [`GPC_ADDR_W-1:0] ofs,
		input gpc_pkg::gpc_cfg_s cfg,
		input logic [NUM_PINS-1:0] levels_in,
		input logic [NUM_PINS-1:0] levels_out);
		logic [DATA_W-1:0] word;
		// reserved and unmapped bits read zero
		word = '0;
		case (ofs)
			`GPC_OFS_PIN2_CFG: begin
				word = cfg;
			end
			`GPC_OFS_PIN_IN: begin
				word[NUM_PINS-1:0] = levels_in;
			end
			`GPC_OFS_PIN_OUT: begin
				word[NUM_PINS-1:0] = levels_out;
			end
			default: begin
				word = '0;
			end
		endcase
		read_mux = word;
	endfunction

	// Answer strobe: one cycle per read request
	always_ff @(posedge mclk) begin
		if (reset) begin
			rvalid_q <= 1'h0;
		end else begin
			rvalid_q <= req.rd;
		end
	end

	// Read data holds until the next read so a slow master can fetch it late
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (req.rd) begin
			rdata_q <= read_mux(req.addr, cfg_q, in_q, out_q);
		end
	end

	assign rdata = rdata_q;
	assign rvalid = rvalid_q;

endmodule

// ==== testbench/gpc_top_props.sv ====
// Port checker for the pin block
`timescale 1ns/10ps
module gpc_top_props #(
	parameter int DATA_W = 8,
	parameter int NUM_PINS = 3
) (
	// Clock and register port
	input wire logic mclk,
	input wire logic reset,
	input wire gpc_pkg::gpc_req_s req,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic rvalid,
	// Pins
	input wire logic [NUM_PINS-1:0] gpout_sel,
	input wire logic [NUM_PINS-1:0] pin_o,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire gpc_pkg::gpc_pull_s pin2_pull
);
	wire cw = req.wr && req.addr == 8'h04;
	wire ow = req.wr && req.addr == 8'h06;
	wire ir = req.rd && req.addr == 8'h05;
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	property p_pull;
		cw ##1 !cw |=> pin2_pull == {$past(req.wdata[3:2], 2) == 2'h2,
			$past(req.wdata[3:2], 2) == 2'h1};
	endproperty
	a_pull: assert property (p_pull) else $error("pull wrong");
	property p_inen;
		cw && !req.wdata[1] ##1 !cw [*2] ##1 ir |=> !rdata[2];
	endproperty
	a_inen: assert property (p_inen) else $error("buffer off");
	property p_oe;
		cw ##1 !cw |=> pin_oe[2] == $past(req.wdata[0], 2);
	endproperty
	a_oe: assert property (p_oe) else $error("oe wrong");
	property p_rin;
		ir |=> rvalid && rdata[7:3] == 5'h00;
	endproperty
	a_rin: assert property (p_rin) else $error("input read");
	property p_rv;
		rvalid |-> $past(req.rd);
	endproperty
	a_rv: assert property (p_rv) else $error("stray rvalid");
	property p_out;
		ow ##1 (!ow && gpout_sel == 3'h7) |=>
			pin_o == $past(req.wdata[2:0], 2);
	endproperty
	a_out: assert property (p_out) else $error("pin out");
	property p_rout;
		req.rd && req.addr == 8'h06 |=> rdata[7:3] == 5'h00;
	endproperty
	a_rout: assert property (p_rout) else $error("reserved");
	c_rd: cover property (ir ##1 rvalid);
	c_cfg: cover property (cw ##2 pin_oe[2]);
	c_out: cover property (ow ##2 pin_o == 3'h7);
endmodule

// ==== testbench/gpc_top_tb.sv ====
// Self-checking bench for the pin block
`timescale 1ns/10ps
module gpc_top_tb;
	logic mclk = 0, reset = 1, rvalid;
	gpc_pkg::gpc_req_s req = '0;
	gpc_pkg::gpc_pull_s pin2_pull;
	logic [7:0] rdata;
	logic [3:0] pin2_mode;
	logic [1:0] other_in_en = 2'h3, other_drv_on = 2'h0;
	logic [2:0] gpout_sel = 3'h7, alt_out = 3'h0, pin_i = 3'h7;
	logic [2:0] pin_o, pin_oe;
	int n_errors = 0, tests_run = 0, cyc = 0;
	always #20 mclk = ~mclk;
	gpc_top i_dut (.mclk, .reset, .req, .rdata, .rvalid, .other_in_en,
		.other_drv_on, .gpout_sel, .alt_out, .pin_i, .pin_o, .pin_oe,
		.pin2_pull, .pin2_mode);
	// ****************************************
	// Helpers
	// ****************************************
	task wrap_up;
		$display("checks=%0d errors=%0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Strobes rise after an edge and stay up exactly one cycle
	task wr(input logic [7:0] a, d);
		@(posedge mclk) #1 req = {2'b10, a, d};
		@(posedge mclk) #1 req = '0;
		@(posedge mclk) #1;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge mclk) #1 req = {2'b01, a, 8'h00};
		@(posedge mclk) #1 req = '0;
		chk({7'h00, rvalid}, 8'h01);
		chk(rdata, e);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		rd(8'h04, 8'h04);
		rd(8'h06, 8'h00);
		chk(8'(pin2_pull), 8'h01);
		chk(8'(pin_oe), 8'h00);
		$display("t_reset done");
	endtask
	task t_cfg;
		for (int p = 0; p < 4; p++) begin
			wr(8'h04, 8'(p * 4 + 1));
			chk(8'(pin2_pull), 8'(p == 3 ? 0 : p));
			chk(8'(pin_oe), 8'h04);
			rd(8'h05, 8'h03);
		end
		wr(8'h04, 8'h02);
		chk(8'(pin_oe), 8'h00);
		rd(8'h05, 8'h07);
		wr(8'h04, 8'hA7);
		rd(8'h04, 8'hA7);
		chk(8'(pin2_mode), 8'h0A); // Stored mode bits
		chk(8'(pin_oe), 8'h04);
		$display("t_cfg done");
	endtask
	task t_out;
		wr(8'h06, 8'hFF);
		chk(8'(pin_o), 8'h07);
		rd(8'h06, 8'h07);
		wr(8'h06, 8'hFB);
		chk(8'(pin_o), 8'h03);
		rd(8'h10, 8'h00);
		$display("t_out done");
	endtask
	// Pins 1 and 2 leave the output register, pin1 buffer off, levels change
	task t_pins;
		@(posedge mclk) #1 pin_i = 3'h6;
		other_in_en = 2'h1;
		other_drv_on = 2'h3;
		gpout_sel = 3'h1;
		alt_out = 3'h4;
		@(posedge mclk) #1;
		chk(8'(pin_o), 8'h05);
		chk(8'(pin_oe), 8'h07);
		rd(8'h05, 8'h04);
		$display("t_pins done");
	endtask
	// ****************************************
	// Run control
	// ****************************************
	// Whole run is under sixty cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			wrap_up;
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		#1 reset = 0;
		t_reset;
		t_cfg;
		t_out;
		t_pins;
		wrap_up;
	end
endmodule
bind gpc_top gpc_top_props #(.DATA_W(DATA_W), .NUM_PINS(NUM_PINS)) i_props (
	.mclk, .reset, .req, .rdata, .rvalid, .gpout_sel, .pin_o, .pin_oe,
	.pin2_pull);
